// file: read_dummy_wrap_defs.svh
// Constants for the read-parameter wrap and dummy-cycle logic.
`ifndef READ_DUMMY_WRAP_DEFS_SVH
`define READ_DUMMY_WRAP_DEFS_SVH

// Address width of the read pointer.
`define RDW_ADDR_W        32
// Field value that selects the per-command default dummy count.
`define RDW_DUMMY_DEFAULT 4'h0
// Default dummy counts of the command families.
`define RDW_DUMMY_EIGHT   4'h8
`define RDW_DUMMY_SIX     4'h6
`define RDW_DUMMY_FOUR    4'h4
// Count that ends the dummy phase on the next edge.
`define RDW_DUMMY_LAST    4'h1
// Burst-length codes and the offset masks they select.
`define RDW_BL_8          2'h0
`define RDW_BL_16         2'h1
`define RDW_BL_32         2'h2
`define RDW_BL_64         2'h3
`define RDW_MASK_8        6'h07
`define RDW_MASK_16       6'h0F
`define RDW_MASK_32       6'h1F
`define RDW_MASK_64       6'h3F
`define RDW_MASK_W        6
// Fast-read command opcodes.
`define RDW_OP_FAST       8'h0B
`define RDW_OP_FAST4      8'h0C
`define RDW_OP_DUAL_OUT   8'h3B
`define RDW_OP_DUAL_OUT4  8'h3C
`define RDW_OP_QUAD_OUT   8'h6B
`define RDW_OP_QUAD_OUT4  8'h6C
`define RDW_OP_DUAL_IO    8'hBB
`define RDW_OP_DUAL_IO4   8'hBC
`define RDW_OP_QUAD_IO    8'hEB
`define RDW_OP_QUAD_IO4   8'hEC
`define RDW_OP_DR         8'h0D
`define RDW_OP_DR4        8'h0E
`define RDW_OP_DUAL_DR    8'hBD
`define RDW_OP_DUAL_DR4   8'hBE
`define RDW_OP_QUAD_DR    8'hED
`define RDW_OP_QUAD_DR4   8'hEE
// Unique-ID and information-row read opcodes.
`define RDW_OP_UID        8'h4B
`define RDW_OP_INFO_ROW   8'h68

`endif

// file: read_dummy_wrap_pkg.sv
// Types shared by the read-parameter wrap and dummy-cycle logic.
package read_dummy_wrap_pkg;

  // Read parameters as loaded by the set-read-parameters commands.
  typedef struct packed {
    logic       quadCommandMode;
    logic [3:0] dummyField;
    logic       wrapEnableBit;
    logic       burstLengthMsb;
    logic       burstLengthLsb;
  } read_params_s;

  // Phases of one read frame at the link.
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_DUMMY = 2'b01,
    ST_DATA  = 2'b10,
    ST_HALT  = 2'b11
  } link_state_e;

endpackage

// file: param_sync.sv
// Toggle handshake that carries the read parameters into the link domain.
`timescale 1ns/1ns
module param_sync (
  input  wire logic                              core_clk,
  input  wire logic                              linkClk,
  input  wire logic                              rst_n,
  input  wire read_dummy_wrap_pkg::read_params_s paramsIn,
  output read_dummy_wrap_pkg::read_params_s      paramsOut,
  output logic                                   busy
);

  read_dummy_wrap_pkg::read_params_s held_r;
  read_dummy_wrap_pkg::read_params_s paramsOut_r;
  logic reqTog_r;
  logic ackSync1_r;
  logic ackSync2_r;
  logic reqSync1_r;
  logic reqSync2_r;
  logic reqSeen_r;
  logic launch;
  logic newReq;

  // A new word launches only once the last one is acknowledged.
  assign busy   = reqTog_r != ackSync2_r;
  assign launch = !busy && (paramsIn != held_r);
  assign newReq = reqSync2_r != reqSeen_r;
  assign paramsOut = paramsOut_r;

  // Core side holds the word stable while the request is in flight.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      held_r     <= '0;
      reqTog_r   <= 1'b0;
      ackSync1_r <= 1'b0;
      ackSync2_r <= 1'b0;
    end else begin
      ackSync1_r <= reqSeen_r;
      ackSync2_r <= ackSync1_r;
      if (launch) begin
        held_r   <= paramsIn;
        reqTog_r <= !reqTog_r;
      end
    end
  end

  // Link side copies the held word when the request toggle arrives.
  always_ff @(posedge linkClk or negedge rst_n) begin
    if (!rst_n) begin
      reqSync1_r  <= 1'b0;
      reqSync2_r  <= 1'b0;
      reqSeen_r   <= 1'b0;
      paramsOut_r <= '0;
    end else begin
      reqSync1_r <= reqTog_r;
      reqSync2_r <= reqSync1_r;
      if (newReq) begin
        reqSeen_r   <= reqSync2_r;
        paramsOut_r <= held_r;
      end
    end
  end

endmodule

// file: read_dummy_wrap_config.sv
// Fast-read dummy-cycle selection and burst wrap address sequencing.
//
// Notes on behaviour
// R1: Wrap bit 0: bursts run across the whole array; length bits ignored.
// R2: Wrap bit 1: bursts wrap at the boundary set by length bits.
// R3: Length code 00/01/10/11 gives 8/16/32/64 byte boundary.
// R4: The four-bit dummy field selects 1 to 15 dummy cycles.
// R5: Field 0 uses each command's default; nonzero is used directly.
// R6: Fast and double-rate fast read default 8 single-wire, 6 quad-command.
// R7: Dual and quad output reads default 8; single-wire mode only.
// R8: Dual-I/O and its double-rate form default 4; single-wire only.
// R9: Quad-I/O and its double-rate form default 6 in both modes.
// R10: Unique-ID and information-row reads follow the fast read.
// R11: Dual-I/O double-rate read is refused in quad-command mode.
// R12: Host picks enough dummy cycles, mode-bit phase included.
// R13: Host floats spare mode-bit lines to avoid I/O contention.
// R14: Host keeps serial clock within the limit for command and count.
// R15: Host loads the settings with the set-read-parameters commands.
// R16: Wrapped address cycles inside the aligned block of burst length.
`timescale 1ns/1ns
`include "read_dummy_wrap_defs.svh"
module read_dummy_wrap_config #(
  parameter int       ADDR_W   = `RDW_ADDR_W,
  parameter bit [7:0] UID_OP   = `RDW_OP_UID,
  parameter bit [7:0] INFO_OP  = `RDW_OP_INFO_ROW
) (
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic              wrapEnableBit,
  input  wire logic              burstLengthMsb,
  input  wire logic              burstLengthLsb,
  input  wire logic [3:0]        dummyField,
  input  wire logic              quadCommandMode,
  output logic                   paramsPending,
  input  wire logic              linkClk,
  input  wire logic              cmdValid,
  input  wire logic [7:0]        cmdOpcode,
  input  wire logic [ADDR_W-1:0] cmdAddr,
  input  wire logic              byteAdvance,
  input  wire logic              frameEnd,
  output logic                   cmdAccept,
  output logic                   cmdReject,
  output logic [3:0]             dummyCount,
  output logic                   dummyPhase,
  output logic                   dataPhase,
  output logic [ADDR_W-1:0]      readAddr
);

  read_dummy_wrap_pkg::read_params_s paramsCore;
  read_dummy_wrap_pkg::read_params_s paramsLink;
  read_dummy_wrap_pkg::link_state_e  state_r;
  read_dummy_wrap_pkg::link_state_e  state_nxt;
  logic              cmdAccept_r;
  logic              cmdReject_r;
  logic [3:0]        dummyCount_r;
  logic [3:0]        dummyLeft_r;
  logic [ADDR_W-1:0] readAddr_r;
  logic [ADDR_W-1:0] readAddr_nxt;

  // Settings arrive already loaded; carry them to the link clock.
  assign paramsCore = '{quadCommandMode: quadCommandMode,
                        dummyField:      dummyField,
                        wrapEnableBit:   wrapEnableBit,
                        burstLengthMsb:  burstLengthMsb,
                        burstLengthLsb:  burstLengthLsb};

  param_sync paramSync (
    .core_clk  (core_clk),
    .linkClk   (linkClk),
    .rst_n     (rst_n),
    .paramsIn  (paramsCore),
    .paramsOut (paramsLink),
    .busy      (paramsPending)
  );

  // Link-domain views of the parameters.
  logic       quadMode;
  logic       wrapOn;
  logic [1:0] burstCode;
  logic [3:0] fieldLink;
  assign quadMode  = paramsLink.quadCommandMode;
  assign wrapOn    = paramsLink.wrapEnableBit;
  assign burstCode = {paramsLink.burstLengthMsb, paramsLink.burstLengthLsb};
  assign fieldLink = paramsLink.dummyField;

  // R3: Burst code selects the offset mask of the wrap block.
  logic [`RDW_MASK_W-1:0] burstMask;
  assign burstMask = (burstCode == `RDW_BL_8)  ? `RDW_MASK_8  :
                     (burstCode == `RDW_BL_16) ? `RDW_MASK_16 :
                     (burstCode == `RDW_BL_32) ? `RDW_MASK_32 :
                                                 `RDW_MASK_64;

  // Opcode decode into command families.
  logic isFast;
  logic isDualOut;
  logic isQuadOut;
  logic isDualIo;
  logic isQuadIo;
  logic isDoubleRate;
  logic isDualIoDr;
  logic isQuadIoDr;
  logic spiOnly;
  logic cmdLegal;
  // R10: Unique-ID and information-row reads join the fast read family.
  assign isFast = cmdOpcode == `RDW_OP_FAST || cmdOpcode == `RDW_OP_FAST4 ||
                  cmdOpcode == UID_OP || cmdOpcode == INFO_OP;
  assign isDualOut = cmdOpcode == `RDW_OP_DUAL_OUT ||
                     cmdOpcode == `RDW_OP_DUAL_OUT4;
  assign isQuadOut = cmdOpcode == `RDW_OP_QUAD_OUT ||
                     cmdOpcode == `RDW_OP_QUAD_OUT4;
  assign isDualIo = cmdOpcode == `RDW_OP_DUAL_IO ||
                    cmdOpcode == `RDW_OP_DUAL_IO4;
  assign isQuadIo = cmdOpcode == `RDW_OP_QUAD_IO ||
                    cmdOpcode == `RDW_OP_QUAD_IO4;
  assign isDoubleRate = cmdOpcode == `RDW_OP_DR || cmdOpcode == `RDW_OP_DR4;
  assign isDualIoDr = cmdOpcode == `RDW_OP_DUAL_DR ||
                      cmdOpcode == `RDW_OP_DUAL_DR4;
  assign isQuadIoDr = cmdOpcode == `RDW_OP_QUAD_DR ||
                      cmdOpcode == `RDW_OP_QUAD_DR4;
  // R11: Single-wire-only commands are refused in quad-command mode.
  assign spiOnly  = isDualOut || isQuadOut || isDualIo || isDualIoDr;
  assign cmdLegal = (isFast || isDoubleRate || isQuadIo || isQuadIoDr ||
                     spiOnly) && !(quadMode && spiOnly);

  // R6: Fast and double-rate fast read: 8 single-wire, 6 quad-command.
  // R7: Dual and quad output reads fall to the 8-cycle default.
  // R8: Dual-I/O families take 4; R9: quad-I/O families take 6.
  logic [3:0] defaultDummy;
  logic [3:0] selDummy;
  assign defaultDummy = (isDualIo || isDualIoDr) ? `RDW_DUMMY_FOUR  :
                        (isQuadIo || isQuadIoDr) ? `RDW_DUMMY_SIX   :
                        (quadMode && !spiOnly)   ? `RDW_DUMMY_SIX   :
                                                   `RDW_DUMMY_EIGHT;
  // R4: Nonzero field gives 1 to 15 cycles.
  // R5: Zero field falls back to the command default.
  assign selDummy = (fieldLink == `RDW_DUMMY_DEFAULT) ? defaultDummy
                                                      : fieldLink;

  // R1: Without wrap the pointer runs linearly over the whole array.
  // R2: With wrap only the offset bits inside the block advance.
  // R16: The block base stays, so the pointer returns to its start.
  logic [ADDR_W-1:0] maskWide;
  logic [ADDR_W-1:0] addrInc;
  logic [ADDR_W-1:0] addrWrap;
  logic [ADDR_W-1:0] addrNext;
  assign maskWide = {{(ADDR_W-`RDW_MASK_W){1'b0}}, burstMask};
  assign addrInc  = readAddr_r + ADDR_W'(1);
  assign addrWrap = (readAddr_r & ~maskWide) | (addrInc & maskWide);
  assign addrNext = wrapOn ? addrWrap : addrInc;

  // Frame sequencing: command, dummy phase, then data.
  logic takeCmd;
  assign takeCmd = cmdValid && state_r == read_dummy_wrap_pkg::ST_IDLE;

  always_comb begin
    state_nxt    = state_r;
    readAddr_nxt = readAddr_r;
    case (state_r)
      read_dummy_wrap_pkg::ST_IDLE: begin
        if (cmdValid) begin
          state_nxt    = cmdLegal ? read_dummy_wrap_pkg::ST_DUMMY
                                  : read_dummy_wrap_pkg::ST_HALT;
          readAddr_nxt = cmdAddr;
        end
      end
      read_dummy_wrap_pkg::ST_DUMMY: begin
        if (dummyLeft_r == `RDW_DUMMY_LAST) begin
          state_nxt = read_dummy_wrap_pkg::ST_DATA;
        end
      end
      read_dummy_wrap_pkg::ST_DATA: begin
        if (byteAdvance) begin
          readAddr_nxt = addrNext;
        end
      end
      read_dummy_wrap_pkg::ST_HALT: begin
        state_nxt = read_dummy_wrap_pkg::ST_HALT;
      end
      default: begin
        state_nxt = read_dummy_wrap_pkg::ST_IDLE;
      end
    endcase
    if (frameEnd) begin
      state_nxt = read_dummy_wrap_pkg::ST_IDLE;
    end
  end

  // State and pointer registers.
  always_ff @(posedge linkClk or negedge rst_n) begin
    if (!rst_n) begin
      state_r    <= read_dummy_wrap_pkg::ST_IDLE;
      readAddr_r <= '0;
    end else begin
      state_r    <= state_nxt;
      readAddr_r <= readAddr_nxt;
    end
  end

  // Command answer and dummy counter.
  always_ff @(posedge linkClk or negedge rst_n) begin
    if (!rst_n) begin
      cmdAccept_r  <= 1'b0;
      cmdReject_r  <= 1'b0;
      dummyCount_r <= '0;
      dummyLeft_r  <= '0;
    end else begin
      cmdAccept_r <= takeCmd && cmdLegal && !frameEnd;
      cmdReject_r <= takeCmd && !cmdLegal;
      if (takeCmd && cmdLegal) begin
        dummyCount_r <= selDummy;
        dummyLeft_r  <= selDummy;
      end else if (state_r == read_dummy_wrap_pkg::ST_DUMMY) begin
        dummyLeft_r <= dummyLeft_r - `RDW_DUMMY_LAST;
      end
    end
  end

  assign cmdAccept  = cmdAccept_r;
  assign cmdReject  = cmdReject_r;
  assign dummyCount = dummyCount_r;
  assign readAddr   = readAddr_r;
  assign dummyPhase = state_r == read_dummy_wrap_pkg::ST_DUMMY;
  assign dataPhase  = state_r == read_dummy_wrap_pkg::ST_DATA;

  // Checks on the link-domain behaviour.
  default clocking linkCb @(posedge linkClk);
  endclocking
  default disable iff (!rst_n);

  logic [ADDR_W-1:0] blockBase;
  logic              cmdFieldZero;
  assign blockBase    = readAddr_r & ~maskWide;
  assign cmdFieldZero = takeCmd && !frameEnd &&
                        fieldLink == `RDW_DUMMY_DEFAULT;

  sequence advanceSeq;
    dataPhase && byteAdvance && !frameEnd;
  endsequence
  sequence acceptFour;
    (cmdAccept && dummyCount == `RDW_DUMMY_FOUR) ##0 (!frameEnd)[*4];
  endsequence

  a_wrap_off_linear: assert property ( // R1
    advanceSeq and !wrapOn |=> readAddr == $past(readAddr) + ADDR_W'(1))
    else $error("Linear burst did not step by one.");
  a_wrap_on_block: assert property ( // R2
    advanceSeq and wrapOn and $stable(paramsLink)
      |=> (readAddr & ~$past(maskWide)) == $past(blockBase))
    else $error("Wrapped burst left its block.");
  a_wrap_to_start: assert property ( // R16
    advanceSeq and wrapOn and (readAddr_r & maskWide) == maskWide
      |=> (readAddr & $past(maskWide)) == '0)
    else $error("Wrapped burst did not return to block start.");
  a_len_sixty_four: assert property ( // R3
    burstCode == `RDW_BL_64 |-> maskWide == ADDR_W'(`RDW_MASK_64))
    else $error("Burst code 11 did not select 64 bytes.");
  a_dummy_direct: assert property ( // R5
    takeCmd && !frameEnd && cmdLegal && fieldLink != `RDW_DUMMY_DEFAULT
      |=> cmdAccept && dummyCount == $past(fieldLink))
    else $error("Nonzero dummy field not used directly.");
  a_fast_default: assert property ( // R6
    cmdFieldZero && cmdOpcode == `RDW_OP_DR
      |=> dummyCount == ($past(quadMode) ? `RDW_DUMMY_SIX : `RDW_DUMMY_EIGHT))
    else $error("Double-rate fast read default wrong.");
  a_quad_out_dflt: assert property ( // R7
    cmdFieldZero && cmdOpcode == `RDW_OP_QUAD_OUT && !quadMode
      |=> cmdAccept && dummyCount == `RDW_DUMMY_EIGHT)
    else $error("Quad output read default wrong.");
  a_dual_io_dflt: assert property ( // R8
    cmdFieldZero && cmdOpcode == `RDW_OP_DUAL_IO && !quadMode
      |=> dummyCount == `RDW_DUMMY_FOUR)
    else $error("Dual-I/O read default wrong.");
  a_quad_io_dflt: assert property ( // R9
    cmdFieldZero && cmdOpcode == `RDW_OP_QUAD_DR4
      |=> cmdAccept && dummyCount == `RDW_DUMMY_SIX)
    else $error("Quad-I/O double-rate default wrong.");
  a_uid_like_fast: assert property ( // R10
    cmdFieldZero && cmdOpcode == UID_OP && !quadMode
      |=> dummyCount == `RDW_DUMMY_EIGHT)
    else $error("Unique-ID read default wrong.");
  a_dual_dr_quad: assert property ( // R11
    takeCmd && quadMode && cmdOpcode == `RDW_OP_DUAL_DR
      |=> cmdReject && !cmdAccept ##1 !dummyPhase)
    else $error("Dual-I/O double-rate accepted in quad mode.");
  a_dummy_length: assert property ( // R4
    acceptFour |=> dataPhase && !dummyPhase)
    else $error("Dummy phase length differs from count.");

endmodule

// file: host_model.sv
// Behavioural serial host that frames read commands at the link side.
`timescale 1ns/1ns
module host_model (
  input  wire logic        paramsPending,
  input  wire logic        cmdAccept,
  input  wire logic        cmdReject,
  input  wire logic [3:0]  dummyCount,
  input  wire logic        dummyPhase,
  input  wire logic        dataPhase,
  input  wire logic [31:0] readAddr,
  output logic             linkClk,
  output logic             cmdValid,
  output logic [7:0]       cmdOpcode,
  output logic [31:0]      cmdAddr,
  output logic             byteAdvance,
  output logic             frameEnd
);
  logic        resAcc;
  logic        resRej;
  logic        resHalt;
  logic        resData;
  logic [1:0]  resEnd;
  logic [3:0]  resCnt;
  int          resLen;
  bit          hung;
  logic [31:0] seen[$];

  // Lines idle low; the link clock only runs inside frames and the reset ticks.
  initial begin
    linkClk = 1'b0;
    cmdValid = 1'b0;
    cmdOpcode = 8'h00;
    cmdAddr = 32'h0;
    byteAdvance = 1'b0;
    frameEnd = 1'b0;
  end

  // One link cycle of 12 ns; inputs change while the clock is low.
  // fixed link pacing
  task automatic tick();
    #6 linkClk = 1'b1;
    #6 linkClk = 1'b0;
  endtask

  // One frame: preamble, command, dummy wait, bytes, deselect.
  task automatic frame(input logic [7:0] op, input logic [31:0] a,
                       input int nAdv);
    int n;
    n = 0;
    seen.delete();
    repeat (4) tick();
    while (paramsPending !== 1'b0 && n < 40) begin
      tick();
      n++;
    end
    hung = (paramsPending !== 1'b0);
    cmdValid = 1'b1;
    cmdOpcode = op;
    cmdAddr = a;
    tick();
    cmdValid = 1'b0;
    cmdOpcode = ~op;
    cmdAddr = ~a;
    resAcc = cmdAccept;
    resRej = cmdReject;
    resCnt = dummyCount;
    resLen = 0;
    while (dummyPhase === 1'b1 && resLen < 20) begin
      resLen++;
      tick();
    end
    hung = hung | (resLen >= 20);
    resData = dataPhase;
    seen.push_back(readAddr);
    // A refused frame must ignore a second command until deselect.
    if (resRej === 1'b1) begin
      tick();
      cmdValid = 1'b1;
      cmdOpcode = 8'h0B;
      tick();
      cmdValid = 1'b0;
      resHalt = cmdAccept | dummyPhase | dataPhase;
    end
    byteAdvance = (nAdv > 0);
    for (int i = 0; i < nAdv; i++) begin
      tick();
      seen.push_back(readAddr);
    end
    byteAdvance = 1'b0;
    frameEnd = 1'b1;
    tick();
    frameEnd = 1'b0;
    resEnd = {dummyPhase, dataPhase};
  endtask
endmodule

// file: tb.sv
// Self-checking bench for the read dummy-cycle and wrap logic.
`timescale 1ns/1ns
module tb;
  logic        core_clk;
  logic        rst_n;
  logic        wrapEnableBit;
  logic        burstLengthMsb;
  logic        burstLengthLsb;
  logic [3:0]  dummyField;
  logic        quadCommandMode;
  logic        paramsPending;
  logic        linkClk;
  logic        cmdValid;
  logic [7:0]  cmdOpcode;
  logic [31:0] cmdAddr;
  logic        byteAdvance;
  logic        frameEnd;
  logic        cmdAccept;
  logic        cmdReject;
  logic [3:0]  dummyCount;
  logic        dummyPhase;
  logic        dataPhase;
  logic [31:0] readAddr;
  logic [31:0] x;
  int          n_fail;
  int          check_count;
  // Opcodes with their single-wire and quad-command defaults; 0 refuses.
  logic [7:0]  opTab [19] = '{8'h0B, 8'h0C, 8'h3B, 8'h3C, 8'h6B, 8'h6C,
    8'hBB, 8'hBC, 8'hEB, 8'hEC, 8'h0D, 8'h0E, 8'hBD, 8'hBE, 8'hED, 8'hEE,
    8'h4B, 8'h68, 8'h00};
  logic [3:0]  spiTab [19] = '{4'h8, 4'h8, 4'h8, 4'h8, 4'h8, 4'h8, 4'h4,
    4'h4, 4'h6, 4'h6, 4'h8, 4'h8, 4'h4, 4'h4, 4'h6, 4'h6, 4'h8, 4'h8, 4'h0};
  logic [3:0]  qTab [19] = '{4'h6, 4'h6, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0,
    4'h0, 4'h6, 4'h6, 4'h6, 4'h6, 4'h0, 4'h0, 4'h6, 4'h6, 4'h6, 4'h6, 4'h0};

  read_dummy_wrap_config uut (
    .core_clk(core_clk), .rst_n(rst_n), .wrapEnableBit(wrapEnableBit),
    .burstLengthMsb(burstLengthMsb), .burstLengthLsb(burstLengthLsb),
    .dummyField(dummyField), .quadCommandMode(quadCommandMode),
    .paramsPending(paramsPending), .linkClk(linkClk),
    .cmdValid(cmdValid), .cmdOpcode(cmdOpcode), .cmdAddr(cmdAddr),
    .byteAdvance(byteAdvance), .frameEnd(frameEnd),
    .cmdAccept(cmdAccept), .cmdReject(cmdReject),
    .dummyCount(dummyCount), .dummyPhase(dummyPhase),
    .dataPhase(dataPhase), .readAddr(readAddr));

  host_model host (
    .paramsPending(paramsPending), .cmdAccept(cmdAccept),
    .cmdReject(cmdReject), .dummyCount(dummyCount),
    .dummyPhase(dummyPhase), .dataPhase(dataPhase),
    .readAddr(readAddr), .linkClk(linkClk), .cmdValid(cmdValid),
    .cmdOpcode(cmdOpcode), .cmdAddr(cmdAddr),
    .byteAdvance(byteAdvance), .frameEnd(frameEnd));

  // Core clock of 10 ns.
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Loads the read parameters between frames.
  // parameter loading
  task automatic setp(input logic w, input logic [1:0] c,
                      input logic [3:0] f, input logic q);
    @(negedge core_clk);
    wrapEnableBit = w;
    {burstLengthMsb, burstLengthLsb} = c;
    dummyField = f;
    quadCommandMode = q;
  endtask

  // Runs one frame; an expected count of zero means a refusal.
  task automatic run(input logic [7:0] op, input logic [31:0] a,
                     input int n, input logic [3:0] e);
    host.frame(op, a, n);
    if (host.hung) begin
      n_fail++;
      complete_run();
    end
    chk(host.resAcc, e != 4'h0);
    chk(host.resRej, e == 4'h0);
    chk(host.resEnd, 2'h0);
    if (e != 4'h0) begin
      chk(host.resCnt, e);
      chk(host.resLen, e);
      chk(host.resData, 1'b1);
      chk(host.seen[0], a);
    end else
      chk(host.resHalt, 1'b0);
  endtask

  // Next read address, wrapping inside the aligned burst block if on.
  function automatic logic [31:0] wrapNext(input logic [31:0] v,
                                           input logic w,
                                           input logic [1:0] c);
    logic [31:0] m;
    m = (32'h8 << c) - 32'h1;
    return w ? ((v & ~m) | ((v + 32'h1) & m)) : v + 32'h1;
  endfunction

  // Cuts a hang short.
  initial begin
    #900000;
    n_fail++;
    complete_run();
  end

  // Main sequence.
  initial begin
    n_fail = 0;
    check_count = 0;
    rst_n = 1'b0;
    wrapEnableBit = 1'b0;
    {burstLengthMsb, burstLengthLsb} = 2'h0;
    dummyField = 4'h0;
    quadCommandMode = 1'b0;
    fork
      repeat (4) @(negedge core_clk);
      repeat (3) host.tick();
    join
    chk(readAddr, 32'h0);
    chk({paramsPending, cmdAccept, dummyCount}, 6'h00);
    rst_n = 1'b1;
    for (int m = 0; m < 2; m++) begin
      setp(1'b0, 2'h0, 4'h0, m[0]);
      for (int i = 0; i < 19; i++) begin
        run(opTab[i], 32'h100, 0, m ? qTab[i] : spiTab[i]);
      end
    end
    for (int f = 1; f < 16; f++) begin
      setp(1'b0, 2'h0, f[3:0], f[0]);
      run(f[0] ? 8'hED : 8'hBD, 32'h200, 1, f[3:0]);
    end
    for (int c = 0; c < 5; c++) begin
      setp(c < 4, (c == 4) ? 2'h3 : c[1:0], 4'h1, 1'b0);
      x = (c < 4) ? 32'h00ABCD3C : 32'hFFFFFFFC;
      run(8'h0B, x, 70, 4'h1);
      for (int i = 1; i < 71; i++) begin
        x = wrapNext(x, c < 4, c[1:0]);
        chk(host.seen[i], x);
      end
    end
    complete_run();
  end
endmodule
